// file: pmc_power_ctrl.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "pmc_cfg.svh"

module pmc_power_ctrl (
    input wire logic ref_clk,
    input wire logic reset,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // Core side
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic port_match,
    input wire logic cmp_low,
    output logic cpu_clk_en,
    output logic periph_clk_en,
    output logic int_osc_en,
    output logic irq_logic_en,
    output logic port_match_en,
    output logic wake_irq,
    output logic reset_req,
    output logic [15:0] boot_addr
);

    // =========================================
    // Declarations
    pmc_pkg::pmc_state_e state_ff;
    pmc_pkg::pmc_state_e nxt_state;
    pmc_pkg::pmc_byte_t gf_ff;
    pmc_pkg::pmc_byte_t osc_ff;
    pmc_pkg::pmc_byte_t vref_ff;
    pmc_pkg::pmc_byte_t cfg_ff;
    pmc_pkg::pmc_byte_t rdata_ff;
    logic wake_irq_ff;
    logic reset_req_ff;
    logic [15:0] boot_addr_ff;

    logic wr_pwr;
    logic wr_osc;
    logic set_idle;
    logic set_stop;
    logic set_susp;
    logic susp_wake;
    logic susp_clear;

    pmc_tmr_if tif ();

    // =========================================
    // Write decode
    assign wr_pwr = reg_wr && (reg_addr == `PMC_ADDR_PWR);
    assign wr_osc = reg_wr && (reg_addr == `PMC_ADDR_OSC);
    assign set_idle = wr_pwr && reg_wdata[`PMC_BIT_IDLE];
    assign set_stop = wr_pwr && reg_wdata[`PMC_BIT_STOP];
    assign set_susp = wr_osc && reg_wdata[`PMC_BIT_SUSP];

    // Wake sources seen in suspend
    assign susp_wake = port_match ||
        (cmp_low && cfg_ff[`PMC_BIT_CMP_WK]);
    assign susp_clear = (state_ff == pmc_pkg::PMC_SUSP) && susp_wake;

    // =========================================
    // Mode sequencer
    // A select written by software only arms the mode; the CPU keeps
    // running until it reports the setting instruction complete.
    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            pmc_pkg::PMC_RUN: begin
                // Stop wins over halt when both land together
                if (set_stop) begin
                    nxt_state = pmc_pkg::PMC_PEND_STOP;
                end else if (set_susp) begin
                    nxt_state = pmc_pkg::PMC_PEND_SUSP;
                end else if (set_idle) begin
                    nxt_state = pmc_pkg::PMC_PEND_IDLE;
                end
            end
            pmc_pkg::PMC_PEND_IDLE: begin
                if (instr_done) begin
                    nxt_state = pmc_pkg::PMC_IDLE;
                end
            end
            pmc_pkg::PMC_PEND_STOP: begin
                if (instr_done) begin
                    nxt_state = pmc_pkg::PMC_STOP;
                end
            end
            pmc_pkg::PMC_PEND_SUSP: begin
                if (instr_done) begin
                    nxt_state = pmc_pkg::PMC_SUSP;
                end
            end
            pmc_pkg::PMC_IDLE: begin
                // An enabled interrupt resumes; the core then services it
                if (irq_pending) begin
                    nxt_state = pmc_pkg::PMC_RUN;
                end
            end
            pmc_pkg::PMC_STOP: begin
                // No exit here: only the reset input leaves stop
                nxt_state = pmc_pkg::PMC_STOP;
            end
            pmc_pkg::PMC_SUSP: begin
                if (susp_wake) begin
                    nxt_state = pmc_pkg::PMC_RUN;
                end
            end
            default: begin
                nxt_state = pmc_pkg::PMC_RUN;
            end
        endcase
    end

    // State register; reset lands in run whatever mode was active
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            state_ff <= pmc_pkg::PMC_RUN;
        end else begin
            state_ff <= nxt_state;
        end
    end

    // =========================================
    // Registers written by software
    // General purpose flags; select bits are not stored at all
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            gf_ff <= `PMC_RST_PWR;
        end else if (wr_pwr) begin
            gf_ff <= {reg_wdata[7:`PMC_GF_LSB], 2'b00};
        end
    end

    // Oscillator control; the suspend bit drops on a wake,
    // and a wake in the same cycle as a write still clears it
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            osc_ff <= `PMC_RST_OSC;
        end else if (wr_osc) begin
            osc_ff <= reg_wdata;
            if (susp_clear) begin
                osc_ff[`PMC_BIT_SUSP] <= 1'b0;
            end
        end else if (susp_clear) begin
            osc_ff[`PMC_BIT_SUSP] <= 1'b0;
        end
    end

    // Voltage reference control, kept for software
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            vref_ff <= `PMC_RST_VREF;
        end else if (reg_wr && (reg_addr == `PMC_ADDR_VREF)) begin
            vref_ff <= reg_wdata;
        end
    end

    // Configuration: watchdog, detector and wake options
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cfg_ff <= `PMC_RST_CFG;
        end else if (reg_wr && (reg_addr == `PMC_ADDR_CFG)) begin
            cfg_ff <= {4'h0, reg_wdata[3:0]};
        end
    end

    // =========================================
    // Read port, data one cycle after the strobe
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            rdata_ff <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `PMC_ADDR_PWR: rdata_ff <= gf_ff;
                `PMC_ADDR_OSC: rdata_ff <= osc_ff;
                `PMC_ADDR_VREF: rdata_ff <= vref_ff;
                `PMC_ADDR_STAT: rdata_ff <= {1'b0, state_ff};
                `PMC_ADDR_CFG: rdata_ff <= cfg_ff;
                default: rdata_ff <= 8'h00;
            endcase
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    assign reg_rdata = rdata_ff;

    // =========================================
    // Wake interrupt request
    // Raised for one cycle on a suspend wake when configured to
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wake_irq_ff <= 1'b0;
        end else begin
            wake_irq_ff <= susp_clear && cfg_ff[`PMC_BIT_WK_IRQ];
        end
    end

    assign wake_irq = wake_irq_ff;

    // =========================================
    // Timer unit
    assign tif.wdt_en = cfg_ff[`PMC_BIT_WDT_EN];
    assign tif.mcd_en = cfg_ff[`PMC_BIT_MCD_EN];
    // Watchdog runs in run and halt, frozen in stop and suspend
    assign tif.wdt_run = (state_ff != pmc_pkg::PMC_STOP) &&
        (state_ff != pmc_pkg::PMC_SUSP);
    assign tif.in_stop = (state_ff == pmc_pkg::PMC_STOP);
    assign tif.wdt_kick = reg_wr && (reg_addr == `PMC_ADDR_KICK);

    pmc_timers u_timers (
        .ref_clk(ref_clk),
        .reset(reset),
        .tif(tif)
    );

    // =========================================
    // Internal reset request
    // The system returns it on the reset input, which clears every mode
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            reset_req_ff <= 1'b0;
        end else begin
            reset_req_ff <= tif.wdt_expire || tif.mcd_expire;
        end
    end

    assign reset_req = reset_req_ff;

    // Start address after any reset
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            boot_addr_ff <= `PMC_BOOT_ADDR;
        end else begin
            boot_addr_ff <= `PMC_BOOT_ADDR;
        end
    end

    assign boot_addr = boot_addr_ff;

    // =========================================
    // Clock and power gating
    // CPU clock stops in every low-power mode; pending states keep it so
    // the setting instruction can finish.
    assign cpu_clk_en = (state_ff == pmc_pkg::PMC_RUN) ||
        (state_ff == pmc_pkg::PMC_PEND_IDLE) ||
        (state_ff == pmc_pkg::PMC_PEND_STOP) ||
        (state_ff == pmc_pkg::PMC_PEND_SUSP);

    // Halt mode keeps peripherals and clocks alive
    assign periph_clk_en = (state_ff != pmc_pkg::PMC_STOP) &&
        (state_ff != pmc_pkg::PMC_SUSP);

    // Internal oscillator off in stop and suspend
    assign int_osc_en = (state_ff != pmc_pkg::PMC_STOP) &&
        (state_ff != pmc_pkg::PMC_SUSP);

    // Interrupt logic asleep in stop and suspend
    assign irq_logic_en = (state_ff != pmc_pkg::PMC_STOP) &&
        (state_ff != pmc_pkg::PMC_SUSP);

    // Port match survives suspend but not stop
    assign port_match_en = (state_ff != pmc_pkg::PMC_STOP);

endmodule : pmc_power_ctrl

// file: pmc_cfg.svh
//
// Contract
// - Halt CPU for the halt mode only once the setting instruction finishes.
// - Halt mode keeps registers, memory, clocks and peripherals running.
// - Enabled interrupt clears halt select, resumes CPU, interrupt then serviced.
// - Reset ending any low-power mode runs normal reset, starts at zero.
// - Enabled watchdog keeps counting in halt mode and resets the device.
// - Stop entered after setting instruction; internal oscillator, CPU, peripherals stop.
// - In stop only the missing-clock detector runs; analog keeps its enables.
// - Stop mode ends only through a reset, never through an interrupt.
// - Enabled missing-clock detector resets in stop after its 100 us timeout.
// - Suspend select halts CPU and internal oscillator after setting instruction.
// - In suspend only the port match logic stays active.
// - Suspend ends on port match, enabled comparator low, or reset.
// - Non-reset suspend wake resumes, servicing the wake interrupt if configured.
// - Halt and stop select bits always read back as zero.
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// Register map, byte addresses on the plain port
`define PMC_ADDR_PWR 8'h00
`define PMC_ADDR_OSC 8'h01
`define PMC_ADDR_VREF 8'h02
`define PMC_ADDR_STAT 8'h03
`define PMC_ADDR_CFG 8'h04
`define PMC_ADDR_KICK 8'h05

// Field positions
`define PMC_BIT_IDLE 0
`define PMC_BIT_STOP 1
`define PMC_GF_LSB 2
`define PMC_BIT_SUSP 5
`define PMC_BIT_ZTC 3
`define PMC_BIT_WDT_EN 0
`define PMC_BIT_MCD_EN 1
`define PMC_BIT_CMP_WK 2
`define PMC_BIT_WK_IRQ 3

// Reset values
`define PMC_RST_PWR 8'h00
`define PMC_RST_OSC 8'h00
`define PMC_RST_VREF 8'h00
`define PMC_RST_CFG 8'h03
`define PMC_BOOT_ADDR 16'h0000

// Timing
`define PMC_CLK_PERIOD_NS 100
`define PMC_MCD_TIMEOUT_US 100
`define PMC_MCD_CYCLES ((`PMC_MCD_TIMEOUT_US * 1000) / `PMC_CLK_PERIOD_NS)
`define PMC_WDT_LIMIT 12'hfff

`endif

// file: pmc_pkg.sv
package pmc_pkg;

    // Power mode state, one-hot
    typedef enum logic [6:0] {
        PMC_RUN = 7'h01,
        PMC_PEND_IDLE = 7'h02,
        PMC_PEND_STOP = 7'h04,
        PMC_PEND_SUSP = 7'h08,
        PMC_IDLE = 7'h10,
        PMC_STOP = 7'h20,
        PMC_SUSP = 7'h40
    } pmc_state_e;

    typedef logic [7:0] pmc_byte_t;

endpackage : pmc_pkg

// file: pmc_tmr_if.sv
`timescale 1ns/1ps

// Link between the mode controller and its timer unit
interface pmc_tmr_if;
    logic wdt_en;
    logic mcd_en;
    logic wdt_run;
    logic in_stop;
    logic wdt_kick;
    logic wdt_expire;
    logic mcd_expire;

    modport ctl (
        output wdt_en,
        output mcd_en,
        output wdt_run,
        output in_stop,
        output wdt_kick,
        input wdt_expire,
        input mcd_expire
    );

    modport tmr (
        input wdt_en,
        input mcd_en,
        input wdt_run,
        input in_stop,
        input wdt_kick,
        output wdt_expire,
        output mcd_expire
    );
endinterface : pmc_tmr_if

// file: pmc_timers.sv
`timescale 1ns/1ps
`include "pmc_cfg.svh"

module pmc_timers (
    input wire logic ref_clk,
    input wire logic reset,
    pmc_tmr_if.tmr tif
);

    localparam logic [9:0] MCD_LAST = 10'(`PMC_MCD_CYCLES - 1);

    logic [11:0] wdt_cnt_ff;
    logic [9:0] mcd_cnt_ff;
    logic wdt_exp_ff;
    logic mcd_exp_ff;

    // =========================================
    // Watchdog
    // Frozen while not running so stop and suspend keep it still
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            wdt_cnt_ff <= 12'h000;
            wdt_exp_ff <= 1'b0;
        end else if (!tif.wdt_en || tif.wdt_kick) begin
            wdt_cnt_ff <= 12'h000;
            wdt_exp_ff <= 1'b0;
        end else if (tif.wdt_run) begin
            wdt_exp_ff <= (wdt_cnt_ff == `PMC_WDT_LIMIT);
            if (wdt_cnt_ff != `PMC_WDT_LIMIT) begin
                wdt_cnt_ff <= wdt_cnt_ff + 12'h001;
            end
        end
    end

    // =========================================
    // Missing-clock detector
    // The system clock is gone in stop, so the detector times the stop
    // period on its own; outside stop the clock is present and it idles.
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            mcd_cnt_ff <= 10'h000;
            mcd_exp_ff <= 1'b0;
        end else if (!tif.mcd_en || !tif.in_stop) begin
            mcd_cnt_ff <= 10'h000;
            mcd_exp_ff <= 1'b0;
        end else begin
            mcd_exp_ff <= (mcd_cnt_ff == MCD_LAST);
            if (mcd_cnt_ff != MCD_LAST) begin
                mcd_cnt_ff <= mcd_cnt_ff + 10'h001;
            end
        end
    end

    assign tif.wdt_expire = wdt_exp_ff;
    assign tif.mcd_expire = mcd_exp_ff;

endmodule : pmc_timers

// file: pmc_props.sv
`timescale 1ns/1ps
`include "pmc_cfg.svh"

// ========
// Mode checks seen only from the top ports
module pmc_props (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic instr_done,
    input wire logic irq_pending,
    input wire logic port_match,
    input wire logic cmp_low,
    input wire logic cpu_clk_en,
    input wire logic periph_clk_en,
    input wire logic int_osc_en,
    input wire logic irq_logic_en,
    input wire logic port_match_en,
    input wire logic wake_irq,
    input wire logic [15:0] boot_addr
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);

    // Modes decoded from the gate outputs
    sequence s_idle;
        !cpu_clk_en && periph_clk_en;
    endsequence
    sequence s_stop;
        !port_match_en;
    endsequence
    sequence s_susp;
        !cpu_clk_en && !int_osc_en && port_match_en;
    endsequence

    AST_ENTRY: assert property ($fell(cpu_clk_en) |-> $past(instr_done))
        else $error("cpu halted before instruction end");
    AST_IDLE_KEEP: assert property (s_idle |-> int_osc_en && irq_logic_en)
        else $error("idle lost clocks");
    AST_IDLE_WAKE: assert property (s_idle ##0 irq_pending |=> cpu_clk_en)
        else $error("idle ignored interrupt");
    AST_BOOT: assert property (boot_addr == `PMC_BOOT_ADDR)
        else $error("boot address not zero");
    AST_STOP_GATE: assert property (s_stop |-> !(periph_clk_en || int_osc_en || irq_logic_en))
        else $error("stop left logic running");
    AST_STOP_HOLD: assert property (s_stop |=> !port_match_en && !cpu_clk_en)
        else $error("stop left without reset");
    AST_SUSP_GATE: assert property (s_susp |-> !periph_clk_en && !irq_logic_en)
        else $error("suspend left logic running");
    AST_SUSP_STAY: assert property (s_susp ##0 (!port_match && !cmp_low) |=> !cpu_clk_en)
        else $error("suspend woke without cause");
    AST_SUSP_WAKE: assert property (s_susp ##0 port_match |=> cpu_clk_en)
        else $error("port match did not wake");
    AST_WAKE_IRQ: assert property ($rose(wake_irq) |-> cpu_clk_en && !$past(int_osc_en) ##1 !wake_irq)
        else $error("wake pulse misplaced");
    AST_SEL_ZERO: assert property (reg_rd && reg_addr == `PMC_ADDR_PWR |=> reg_rdata[1:0] == 2'h0)
        else $error("select bits read nonzero");
endmodule : pmc_props

bind pmc_power_ctrl pmc_props u_props (.*);

// file: pmc_core_model.sv
`timescale 1ns/1ps

// ========
// Core model: finishes an instruction every cycle, or every eighth when slow
module pmc_core_model (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic slow,
    output logic instr_done
);
    logic [2:0] cnt_ff;

    // Free phase counter; slow mode stands for multi-byte opcodes
    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            cnt_ff <= 3'h0;
        end else begin
            cnt_ff <= cnt_ff + 3'h1;
        end
    end
    assign instr_done = !slow || (cnt_ff == 3'h7);
endmodule : pmc_core_model

// file: power_mode_controller_tb_top.sv
`timescale 1ns/1ps

// ========
// Bench for the power mode controller
module power_mode_controller_tb_top;
    logic ref_clk = 1'b0;
    logic tb_rst = 1'b1;
    logic loop_rst = 1'b0;
    logic reset;
    logic [7:0] reg_addr = 8'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic irq_pending = 1'b0;
    logic port_match = 1'b0;
    logic cmp_low = 1'b0;
    logic slow = 1'b0;
    logic [7:0] reg_rdata, d;
    logic instr_done, cpu_clk_en, periph_clk_en, int_osc_en;
    logic irq_logic_en, port_match_en, wake_irq, reset_req;
    logic [15:0] boot_addr;
    int bad_count = 0;
    int n_compared = 0;
    int cyc = 0;
    int n, t0, el;

    // Expiry must come back as a device reset, one edge later
    assign reset = tb_rst | loop_rst;
    always @(posedge ref_clk) loop_rst <= reset_req;
    always @(posedge ref_clk) cyc <= cyc + 1;
    initial begin
        forever #50 ref_clk = ~ref_clk;
    end

    pmc_power_ctrl dut (.*);
    pmc_core_model core (.*);

    // ========
    // Shared tasks
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    // Data stand only in the cycle after the read strobe
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    task automatic wait_cpu(input logic v);
        for (n = 0; n < 20 && cpu_clk_en !== v; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 20) begin
            bad_count++;
            report_and_stop();
        end
    endtask : wait_cpu
    // Cycles from t0 to the expiry request, then let the reset pass
    task automatic wait_trip;
        for (n = 0; n < 5000 && reset_req !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (n == 5000) begin
            bad_count++;
            report_and_stop();
        end
        el = cyc - t0;
        repeat (3) @(posedge ref_clk);
    endtask : wait_trip
    task automatic do_reset;
        @(posedge ref_clk);
        tb_rst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        tb_rst <= 1'b0;
    endtask : do_reset

    // ========
    // Scenarios
    task automatic t_regs;
        rd(8'h04);
        check(d, 8'h03);
        rd(8'h03);
        check(d, 8'h01);
        check(boot_addr, 16'h0000);
        wr(8'h03, 8'h10);
        rd(8'h07);
        check(d, 8'h00);
        wr(8'h00, 8'hfc);
        rd(8'h00);
        check(d, 8'hfc);
    endtask : t_regs
    task automatic t_idle;
        slow <= 1'b1;
        wr(8'h00, 8'hfd);
        wait_cpu(1'b0);
        check({periph_clk_en, int_osc_en, irq_logic_en}, 3'h7);
        rd(8'h03);
        check(d, 8'h10);
        rd(8'h00);
        check(d, 8'hfc);
        irq_pending <= 1'b1;
        wait_cpu(1'b1);
        irq_pending <= 1'b0;
        rd(8'h03);
        check(d, 8'h01);
    endtask : t_idle
    task automatic t_susp;
        wr(8'h02, 8'h08);
        wr(8'h04, 8'h0f);
        wr(8'h01, 8'h20);
        wait_cpu(1'b0);
        check({periph_clk_en, int_osc_en, irq_logic_en, port_match_en}, 4'h1);
        cmp_low <= 1'b1;
        wait_cpu(1'b1);
        check(wake_irq, 1'b1);
        cmp_low <= 1'b0;
        rd(8'h01);
        check(d, 8'h00);
        wr(8'h04, 8'h03);
        wr(8'h01, 8'h20);
        wait_cpu(1'b0);
        cmp_low <= 1'b1;
        repeat (4) @(posedge ref_clk);
        #1 check(cpu_clk_en, 1'b0);
        port_match <= 1'b1;
        wait_cpu(1'b1);
        check(wake_irq, 1'b0);
        port_match <= 1'b0;
        cmp_low <= 1'b0;
    endtask : t_susp
    // Stop with halt in the same write; detector ends it
    task automatic t_stop;
        wr(8'h00, 8'hff);
        wait_cpu(1'b0);
        t0 = cyc;
        check(port_match_en, 1'b0);
        rd(8'h00);
        check(d, 8'hfc);
        irq_pending <= 1'b1;
        port_match <= 1'b1;
        repeat (5) @(posedge ref_clk);
        #1 check({cpu_clk_en, irq_logic_en}, 2'h0);
        wait_trip();
        check(el >= 995 && el <= 1005, 1'b1);
        irq_pending <= 1'b0;
        port_match <= 1'b0;
        rd(8'h03);
        check(d, 8'h01);
        check(boot_addr, 16'h0000);
    endtask : t_stop
    // Watchdog keeps running through a halt with no interrupt
    task automatic t_wdt;
        wr(8'h05, 8'h00);
        #1 t0 = cyc;
        wr(8'h00, 8'h01);
        wait_cpu(1'b0);
        wait_trip();
        check(el >= 4090 && el <= 4105, 1'b1);
        rd(8'h03);
        check(d, 8'h01);
    endtask : t_wdt

    // Main sequence
    initial begin
        repeat (3) @(posedge ref_clk);
        tb_rst <= 1'b0;
        t_regs();
        t_idle();
        do_reset();
        t_susp();
        do_reset();
        t_stop();
        t_wdt();
        report_and_stop();
    end
endmodule : power_mode_controller_tb_top
